// [rtl/eeprom_pkg.sv]
// Shared constants of the two-wire EEPROM target and its bus controller
package eeprom_pkg;

  // Clock and bus rates
  localparam int unsigned SYS_CLK_MHZ   = 100;
  localparam int unsigned SCL_KHZ       = 250;
  localparam int unsigned SCL_QTR_CYC   = (SYS_CLK_MHZ * 1000) / (SCL_KHZ * 4);
  localparam int unsigned DIV_W         = 8;

  // Spike suppression on the bus inputs
  localparam int unsigned SPIKE_NS      = 50;
  localparam int unsigned SPIKE_CYC     = (SPIKE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned FILT_W        = 3;

  // Self-timed write cycle
  localparam int unsigned WRITE_TIME_MS = 5;
  localparam int unsigned WRITE_CYC     = WRITE_TIME_MS * 1000 * SYS_CLK_MHZ;
  localparam int unsigned TIMER_W       = 19;

  // Control byte layout and array geometry
  localparam logic [3:0]  DEV_CODE      = 4'hA;
  localparam int unsigned CODE_LSB      = 4;
  localparam int unsigned SEL_LSB       = 1;
  localparam int unsigned DIR_BIT       = 0;
  localparam int unsigned MEM_DEPTH     = 256;
  localparam int unsigned PAGE_SIZE     = 16;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [7:0]  SH_RESET      = 8'hFF;

endpackage

// [rtl/two_wire_if.sv]
// Open-drain two-wire bus joining the controller and the EEPROM target
`timescale 1ns/10ps
interface two_wire_if;
  logic scl_o;       // Controller clock drive value
  logic scl_oe;      // Controller drives the clock line
  logic ctl_sda_o;   // Controller data drive value
  logic ctl_sda_oe;  // Controller drives the data line
  logic tgt_sda_o;   // Target data drive value
  logic tgt_sda_oe;  // Target drives the data line
  logic scl;         // Resolved clock line level
  logic sda;         // Resolved data line level

  // Wired-AND with pull-up: any enabled low driver pulls the line low
  assign scl = !(scl_oe && !scl_o);
  assign sda = !(ctl_sda_oe && !ctl_sda_o) && !(tgt_sda_oe && !tgt_sda_o);

  modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe);
  modport controller (input scl, input sda, output scl_o, output scl_oe,
                      output ctl_sda_o, output ctl_sda_oe);
endinterface

// [rtl/glitch_filter.sv]
// Two-flop synchroniser followed by a stability filter for one bus line
`timescale 1ns/10ps
module glitch_filter (
  input  logic sys_clk,  // System clock
  input  logic rst_b,    // Asynchronous reset, active low
  input  logic raw,      // Asynchronous line level
  output logic clean     // Filtered level
);
  logic                           sync1_r;
  logic                           sync2_r;
  logic                           clean_r;
  logic [eeprom_pkg::FILT_W-1:0]  cnt_r;

  // Level must hold for the spike time before it is passed on
  wire differ = sync2_r != clean_r;
  wire settle = cnt_r == eeprom_pkg::FILT_W'(eeprom_pkg::SPIKE_CYC - 1);

  // Synchroniser, idle bus reads high
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end
    else
    begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end

  // Stability counter
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt_r   <= '0;
      clean_r <= 1'b1;
    end
    else if (!differ)
      cnt_r <= '0;
    else if (settle)
    begin
      cnt_r   <= '0;
      clean_r <= sync2_r;
    end
    else
      cnt_r <= cnt_r + 1'b1;

  assign clean = clean_r;
endmodule

// [rtl/eeprom_target.sv]
// Two-wire EEPROM target: bus front end, page buffer, array and write timer
`timescale 1ns/10ps
module eeprom_target #(
  parameter int unsigned WRITE_CYC = eeprom_pkg::WRITE_CYC  // Write cycle in clocks
) (
  input  logic        sys_clk,           // System clock
  input  logic        rst_b,             // Asynchronous reset, active low
  two_wire_if.target  bus,               // Shared serial bus
  input  logic        chip_sel_pin_msb,  // Select strap, top bit
  input  logic        chip_sel_pin_mid,  // Select strap, middle bit
  input  logic        chip_sel_pin_lsb,  // Select strap, low bit
  input  logic        write_protect_pin, // High blocks array writes
  input  logic [7:0]  rd_addr,           // Array inspection address
  output logic [7:0]  rd_data,           // Array byte, one cycle later
  output logic        write_busy         // Internal write cycle running
);
  typedef enum logic [2:0] {
    D_IDLE   = 3'b000,
    D_CTRL   = 3'b001,
    D_ADDR   = 3'b010,
    D_DATA   = 3'b011,
    D_TX     = 3'b100,
    D_IGNORE = 3'b101
  } dev_e;

  dev_e                              state_r;
  logic [3:0]                        bit_r;
  logic                              in_ack_r;
  logic                              nack_r;
  logic [7:0]                        sh_r;
  logic [7:0]                        ptr_r;
  logic                              sda_low_r;
  logic                              scl_q_r;
  logic                              sda_q_r;
  logic [3:0]                        pin_s1_r;
  logic [3:0]                        pin_s2_r;
  logic [eeprom_pkg::PAGE_SIZE-1:0]  vld_r;
  logic                              busy_r;
  logic [eeprom_pkg::TIMER_W-1:0]    timer_r;
  logic [7:0]                        rd_data_r;
  logic [7:0]                        page_buf [0:eeprom_pkg::PAGE_SIZE-1];
  logic [7:0]                        mem      [0:eeprom_pkg::MEM_DEPTH-1];
  logic                              scl_f;
  logic                              sda_f;

  glitch_filter u_scl_filt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .raw     (bus.scl),
    .clean   (scl_f)
  );

  glitch_filter u_sda_filt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .raw     (bus.sda),
    .clean   (sda_f)
  );

  // Straps and protect pin pass two flops
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= {chip_sel_pin_msb, chip_sel_pin_mid, chip_sel_pin_lsb, write_protect_pin};
      pin_s2_r <= pin_s1_r;
    end

  // Previous filtered levels for edge finding
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end

  // Bus events
  wire scl_rise  = scl_f && !scl_q_r;
  wire scl_fall  = !scl_f && scl_q_r;
  wire start_det = scl_f && scl_q_r && sda_q_r && !sda_f;
  wire stop_det  = scl_f && scl_q_r && !sda_q_r && sda_f;

  // Byte framing: byte_end opens the ninth slot, slot_end closes it
  wire active    = (state_r != D_IDLE) && (state_r != D_IGNORE);
  wire byte_end  = active && scl_fall && !in_ack_r && (bit_r == eeprom_pkg::BITS_PER_BYTE);
  wire slot_end  = active && scl_fall && in_ack_r;
  wire wp_s      = pin_s2_r[0];
  wire [2:0] sel_s = pin_s2_r[3:1];

  wire code_ok   = sh_r[eeprom_pkg::CODE_LSB +: 4] == eeprom_pkg::DEV_CODE;
  wire sel_ok    = sh_r[eeprom_pkg::SEL_LSB +: 3] == sel_s;
  wire ctrl_hit  = code_ok && sel_ok && !busy_r;
  wire dir_read  = sh_r[eeprom_pkg::DIR_BIT];
  wire ack_now   = (state_r == D_CTRL) ? ctrl_hit : ((state_r != D_TX) && !busy_r);

  // Array byte for transmit: next location once a read is under way
  wire [7:0] tx_addr  = (state_r == D_TX) ? ptr_r + 8'h01 : ptr_r;
  wire [7:0] mem_byte = mem[tx_addr];

  // Page buffer and write launch
  wire data_take = byte_end && (state_r == D_DATA);
  // stop after buffered data starts the write cycle
  wire launch    = stop_det && (state_r == D_DATA) && (|vld_r) && !busy_r;
  // protect pin gates the array update
  wire commit    = launch && !wp_s;

  // Bit engine and protocol state
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      state_r   <= D_IDLE;
      bit_r     <= '0;
      in_ack_r  <= 1'b0;
      nack_r    <= 1'b0;
      sh_r      <= eeprom_pkg::SH_RESET;
      ptr_r     <= '0;
      sda_low_r <= 1'b0;
    end
    else if (start_det)
    begin
      state_r   <= D_CTRL;
      bit_r     <= '0;
      in_ack_r  <= 1'b0;
      sda_low_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r   <= D_IDLE;
      in_ack_r  <= 1'b0;
      sda_low_r <= 1'b0;
    end
    else if (active)
    begin
      if (scl_rise && !in_ack_r)
      begin
        sh_r  <= {sh_r[6:0], sda_f};
        bit_r <= bit_r + 4'h1;
      end
      if (scl_rise && in_ack_r)
        nack_r <= sda_f;
      if (byte_end)
      begin
        in_ack_r  <= 1'b1;
        // drive low for the acknowledge pulse
        sda_low_r <= ack_now;
        if (state_r == D_CTRL && !ctrl_hit)
          state_r <= D_IGNORE;
        if (state_r == D_ADDR)
          ptr_r <= sh_r;
        // low nibble wraps inside the page
        if (state_r == D_DATA)
          ptr_r <= {ptr_r[7:4], ptr_r[3:0] + 4'h1};
      end
      // transmit bits change after clock fall
      else if (scl_fall && !in_ack_r && state_r == D_TX)
        sda_low_r <= !sh_r[7];
      if (slot_end)
      begin
        in_ack_r  <= 1'b0;
        bit_r     <= '0;
        sda_low_r <= 1'b0;
        case (state_r)
          D_CTRL:
            if (dir_read)
            begin
              state_r   <= D_TX;
              sh_r      <= mem_byte;
              sda_low_r <= !mem_byte[7];
            end
            else
              state_r <= D_ADDR;
          D_ADDR:
            state_r <= D_DATA;
          D_TX:
          begin
            // pointer wraps within this array only
            ptr_r <= ptr_r + 8'h01;
            // controller no-ack: release and wait for stop
            if (nack_r)
              state_r <= D_IGNORE;
            else
            begin
              sh_r      <= mem_byte;
              sda_low_r <= !mem_byte[7];
            end
          end
          default:
            state_r <= state_r;
        endcase
      end
    end

  // page buffer entries, later bytes overwrite earlier ones
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      vld_r <= '0;
    else if (start_det || launch)
      vld_r <= '0;
    else if (data_take)
      vld_r[ptr_r[3:0]] <= 1'b1;

  // Buffer contents need no reset
  always_ff @(posedge sys_clk)
    if (data_take)
      page_buf[ptr_r[3:0]] <= sh_r;

  // write timer; runs even when protected
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      busy_r  <= 1'b0;
      timer_r <= '0;
    end
    else if (launch)
    begin
      busy_r  <= 1'b1;
      timer_r <= eeprom_pkg::TIMER_W'(WRITE_CYC - 1);
    end
    else if (busy_r)
    begin
      if (timer_r == '0)
        busy_r <= 1'b0;
      else
        timer_r <= timer_r - 1'b1;
    end

  always_ff @(posedge sys_clk)
    if (commit)
      for (int i = 0; i < eeprom_pkg::PAGE_SIZE; i++)
        if (vld_r[i])
          mem[{ptr_r[7:4], i[3:0]}] <= page_buf[i];

  // Inspection port
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      rd_data_r <= '0;
    else
      rd_data_r <= mem[rd_addr];

  // Open-drain data drive: only ever pulls low
  assign bus.tgt_sda_o  = 1'b0;
  assign bus.tgt_sda_oe = sda_low_r;
  assign rd_data        = rd_data_r;
  assign write_busy     = busy_r;
endmodule

// [rtl/eeprom_controller.sv]
// Two-wire bus controller issuing page writes and single-byte reads
`timescale 1ns/10ps
module eeprom_controller #(
  parameter int unsigned WRITE_CYC = eeprom_pkg::WRITE_CYC  // Post-write wait in clocks
) (
  input  logic            sys_clk,    // System clock
  input  logic            rst_b,      // Asynchronous reset, active low
  two_wire_if.controller  bus,        // Shared serial bus
  input  logic            cmd_valid,  // Command offered
  output logic            cmd_ready,  // Command taken when both high
  input  logic [7:0]      cmd_ctrl,   // Control byte to send
  input  logic [7:0]      cmd_addr,   // Word address for writes
  input  logic            wr_valid,   // Write data offered
  output logic            wr_ready,   // Write data taken when both high
  input  logic [7:0]      wr_data,    // Write data byte
  input  logic            wr_last,    // Final byte of the page
  output logic [7:0]      rd_data,    // Byte read back
  output logic            done,       // One-cycle pulse at end of stop
  output logic            nack_err    // Target did not acknowledge
);
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_START = 2'b01,
    M_BYTE  = 2'b10,
    M_STOP  = 2'b11
  } ctl_e;

  ctl_e                            state_r;
  logic [1:0]                      q_r;
  logic [eeprom_pkg::DIV_W-1:0]    div_r;
  logic [3:0]                      bit_r;
  logic [1:0]                      phase_r;
  logic [3:0]                      col_r;
  logic [7:0]                      sh_r;
  logic [7:0]                      addr_r;
  logic                            rd_mode_r;
  logic                            last_r;
  logic                            ack_r;
  logic                            wrote_r;
  logic                            scl_low_r;
  logic                            sda_low_r;
  logic [1:0]                      scl_s_r;
  logic [1:0]                      sda_s_r;
  logic [7:0]                      rd_data_r;
  logic                            done_r;
  logic                            err_r;
  logic [eeprom_pkg::TIMER_W-1:0]  hold_r;

  // Bus pins pass two flops
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], bus.scl};
      sda_s_r <= {sda_s_r[0], bus.sda};
    end

  // Quarter-period enable; stalls at byte end while data is missing
  wire sending   = !(rd_mode_r && phase_r != 2'h0);
  wire at_end    = state_r == M_BYTE && q_r == 2'h3 && bit_r == eeprom_pkg::BITS_PER_BYTE;
  wire need_data = at_end && !rd_mode_r && phase_r != 2'h0 && !last_r && ack_r;
  wire tick_raw  = div_r == eeprom_pkg::DIV_W'(eeprom_pkg::SCL_QTR_CYC - 1);
  wire tick      = tick_raw && !(need_data && !wr_valid);
  // start only on an idle bus; wait out the write cycle
  wire bus_idle  = scl_s_r[1] && sda_s_r[1] && hold_r == '0;
  assign cmd_ready = state_r == M_IDLE && bus_idle;
  assign wr_ready  = tick_raw && need_data;

  // Divider
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      div_r <= '0;
    else if (state_r == M_IDLE || tick)
      div_r <= '0;
    else if (!tick_raw)
      div_r <= div_r + 1'b1;

  // Post-write hold timer
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      hold_r <= '0;
    else if (state_r == M_STOP && tick && q_r == 2'h3 && wrote_r)
      hold_r <= eeprom_pkg::TIMER_W'(WRITE_CYC);
    else if (hold_r != '0)
      hold_r <= hold_r - 1'b1;

  // Sequencer
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      state_r   <= M_IDLE;
      q_r       <= '0;
      bit_r     <= '0;
      phase_r   <= '0;
      col_r     <= '0;
      sh_r      <= eeprom_pkg::SH_RESET;
      addr_r    <= '0;
      rd_mode_r <= 1'b0;
      last_r    <= 1'b0;
      ack_r     <= 1'b0;
      wrote_r   <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      rd_data_r <= '0;
      done_r    <= 1'b0;
      err_r     <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (state_r == M_IDLE && cmd_valid && cmd_ready)
      begin
        state_r   <= M_START;
        q_r       <= '0;
        bit_r     <= '0;
        phase_r   <= '0;
        sh_r      <= cmd_ctrl;
        addr_r    <= cmd_addr;
        col_r     <= cmd_addr[3:0];
        rd_mode_r <= cmd_ctrl[eeprom_pkg::DIR_BIT];
        last_r    <= 1'b0;
        wrote_r   <= 1'b0;
        err_r     <= 1'b0;
      end
      else if (tick)
      begin
        q_r <= q_r + 2'h1;
        case (state_r)
          M_START:
            case (q_r)
              2'h1:    sda_low_r <= 1'b1;
              2'h2:    scl_low_r <= 1'b1;
              2'h3:    state_r   <= M_BYTE;
              default: sda_low_r <= 1'b0;
            endcase
          M_BYTE:
            case (q_r)
              // data changes with clock low; release on the read's slot
              2'h0:    sda_low_r <= (bit_r != eeprom_pkg::BITS_PER_BYTE) && sending && !sh_r[7];
              2'h1:    scl_low_r <= 1'b0;
              2'h2:
                if (bit_r != eeprom_pkg::BITS_PER_BYTE)
                  sh_r <= {sh_r[6:0], sda_s_r[1]};
                else
                  // target acknowledge sampled in the ninth pulse
                  ack_r <= !sda_s_r[1];
              default:
              begin
                scl_low_r <= 1'b1;
                bit_r     <= bit_r + 4'h1;
                if (bit_r == eeprom_pkg::BITS_PER_BYTE)
                begin
                  bit_r <= '0;
                  if (sending && !ack_r)
                  begin
                    err_r   <= 1'b1;
                    state_r <= M_STOP;
                  end
                  else if (rd_mode_r && phase_r != 2'h0)
                  begin
                    rd_data_r <= sh_r;
                    state_r   <= M_STOP;
                  end
                  else if (rd_mode_r)
                  begin
                    phase_r <= 2'h1;
                    sh_r    <= eeprom_pkg::SH_RESET;
                  end
                  else if (phase_r == 2'h0)
                  begin
                    phase_r <= 2'h1;
                    sh_r    <= addr_r;
                  end
                  else if (last_r)
                    state_r <= M_STOP;
                  else
                  begin
                    phase_r <= 2'h2;
                    sh_r    <= wr_data;
                    wrote_r <= 1'b1;
                    col_r   <= col_r + 4'h1;
                    // never run past the page end
                    last_r  <= wr_last || col_r == 4'hF;
                  end
                end
              end
            endcase
          M_STOP:
            case (q_r)
              2'h0:    sda_low_r <= 1'b1;
              2'h1:    scl_low_r <= 1'b0;
              2'h2:    sda_low_r <= 1'b0;
              default:
              begin
                state_r <= M_IDLE;
                done_r  <= 1'b1;
              end
            endcase
          default:
            state_r <= M_IDLE;
        endcase
      end
    end

  // Open-drain drives
  assign bus.scl_o      = 1'b0;
  assign bus.scl_oe     = scl_low_r;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_sda_oe = sda_low_r;
  assign rd_data        = rd_data_r;
  assign done           = done_r;
  assign nack_err       = err_r;
endmodule

// [tb/two_wire_monitor.sv]
// Protocol checker for the two-wire bus between controller and target
`timescale 1ns/10ps
module two_wire_monitor (
  input logic sys_clk,     // System clock
  input logic rst_b,       // Reset, active low
  input logic scl_o,       // Controller clock value
  input logic scl_oe,      // Controller pulls clock
  input logic ctl_sda_o,   // Controller data value
  input logic ctl_sda_oe,  // Controller pulls data
  input logic tgt_sda_o,   // Target data value
  input logic tgt_sda_oe,  // Target pulls data
  input logic scl,         // Resolved clock
  input logic sda          // Resolved data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Acknowledge held past the clock fall
  sequence s_ack_fall;
    $fell(scl) && tgt_sda_oe;
  endsequence
  sequence s_ack_hold;
    tgt_sda_oe [*5];
  endsequence

  property p_tgt_open;
    !tgt_sda_o;
  endproperty
  property p_ctl_open;
    !ctl_sda_o && !scl_o;
  endproperty
  // Both may pull low while the clock is low; never across a high phase
  property p_one_driver;
    scl |-> !(ctl_sda_oe && tgt_sda_oe);
  endproperty
  property p_ack_hold;
    s_ack_fall |-> s_ack_hold;
  endproperty
  property p_ack_low;
    $rose(tgt_sda_oe) |-> !scl [*8];
  endproperty
  property p_tgt_change;
    $changed(tgt_sda_oe) |-> !scl;
  endproperty
  property p_start;
    $fell(sda) && scl |-> ctl_sda_oe && !tgt_sda_oe;
  endproperty
  property p_scl_high;
    $rose(scl) |-> scl [*8];
  endproperty

  // Checks on the wire
  a_tgt_open: assert property (p_tgt_open) else $error("target drives data high");
  a_ctl_open: assert property (p_ctl_open) else $error("controller drives high");
  a_one_driver: assert property (p_one_driver) else $error("both drive data, clock high");
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  a_ack_low: assert property (p_ack_low) else $error("ack raised near clock high");
  a_tgt_change: assert property (p_tgt_change) else $error("target moved with clock high");
  a_start: assert property (p_start) else $error("bad start condition");
  a_scl_high: assert property (p_scl_high) else $error("clock pulse too short");
endmodule

// [tb/tb_serial_eeprom_slave_write_path.sv]
// Bench: controller writes pages into the target across the bus
`timescale 1ns/10ps
module tb_serial_eeprom_slave_write_path;
  localparam int unsigned WCYC = 2000;
  logic       sys_clk   = 1'b0;
  logic       rst_b     = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       cmd_ready;
  logic [7:0] cmd_ctrl  = 8'h00;
  logic [7:0] cmd_addr  = 8'h00;
  logic       wr_valid  = 1'b0;
  logic       wr_ready;
  logic [7:0] wr_data   = 8'h00;
  logic       wr_last   = 1'b0;
  logic       done;
  logic       nack_err;
  logic       wp        = 1'b0;
  logic [7:0] rd_addr   = 8'h00;
  logic [7:0] rd_data;
  logic       write_busy;
  logic [7:0] ctl_rd_data;
  int         fail_count = 0;
  int         cmp_count  = 0;
  int         busy_len   = 0;
  two_wire_if bus_if ();

  // Both ends and the wire checker
  eeprom_controller #(.WRITE_CYC(WCYC)) eeprom_controller_inst (.sys_clk(sys_clk),
    .rst_b(rst_b), .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_ctrl(cmd_ctrl), .cmd_addr(cmd_addr), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .wr_last(wr_last), .rd_data(ctl_rd_data), .done(done),
    .nack_err(nack_err));
  eeprom_target #(.WRITE_CYC(WCYC)) eeprom_target_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .bus(bus_if), .chip_sel_pin_msb(1'b1), .chip_sel_pin_mid(1'b0), .chip_sel_pin_lsb(1'b1),
    .write_protect_pin(wp), .rd_addr(rd_addr), .rd_data(rd_data), .write_busy(write_busy));
  two_wire_monitor two_wire_monitor_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .scl_o(bus_if.scl_o), .scl_oe(bus_if.scl_oe), .ctl_sda_o(bus_if.ctl_sda_o),
    .ctl_sda_oe(bus_if.ctl_sda_oe), .tgt_sda_o(bus_if.tgt_sda_o),
    .tgt_sda_oe(bus_if.tgt_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  // Clock and busy-length counter
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (write_busy === 1'b1)
      busy_len++;

  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Array byte via the inspection port
  task automatic peek(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    rd_addr = a;
    repeat (2) @(negedge sys_clk);
    check({8'h00, exp}, {8'h00, rd_data});
  endtask

  // One command with up to two data bytes, then the write-cycle wait
  task automatic run_cmd(input logic [7:0] ctrl, addr, d0, d1, input int n);
    int  i;
    int  k;
    logic ch;
    logic wh;
    k = 0;
    ch = 1'b0;
    wh = 1'b0;
    busy_len = 0;
    @(negedge sys_clk);
    cmd_ctrl = ctrl;
    cmd_addr = addr;
    cmd_valid = 1'b1;
    wr_valid = 1'b1;
    wr_data = d0;
    wr_last = (n == 1);
    for (i = 0; i < 60000 && done !== 1'b1; i++)
    begin
      @(negedge sys_clk);
      if (ch)
        cmd_valid = 1'b0;
      if (wh)
      begin
        k++;
        wr_data = d1;
        wr_last = 1'b1;
        wr_valid = (k < n);
      end
      ch = cmd_valid && (cmd_ready === 1'b1);
      wh = wr_valid && (wr_ready === 1'b1);
    end
    wr_valid = 1'b0;
    cmd_valid = 1'b0;
    if (i >= 60000)
      check(16'h0000, 16'h0001);
    for (i = 0; i < WCYC + 1000 && cmd_ready !== 1'b1; i++)
      @(negedge sys_clk);
  endtask

  task automatic t_page;
    run_cmd(8'hAA, 8'h3E, 8'h5A, 8'hC3, 2);
    check(16'h0000, {15'h0000, nack_err});
    check(16'h07D0, busy_len[15:0]);
    peek(8'h3E, 8'h5A);
    peek(8'h3F, 8'hC3);
    $display("test page write done");
  endtask

  task automatic t_bad;
    run_cmd(8'hA8, 8'h3E, 8'h00, 8'h00, 1);
    check(16'h0001, {15'h0000, nack_err});
    run_cmd(8'hBA, 8'h3E, 8'h00, 8'h00, 1);
    check(16'h0001, {15'h0000, nack_err});
    check(16'h0000, busy_len[15:0]);
    peek(8'h3E, 8'h5A);
    $display("test select mismatch done");
  endtask

  task automatic t_protect;
    wp = 1'b1;
    run_cmd(8'hAA, 8'h3E, 8'h11, 8'h00, 1);
    check(16'h0000, {15'h0000, nack_err});
    check(16'h07D0, busy_len[15:0]);
    peek(8'h3E, 8'h5A);
    wp = 1'b0;
    $display("test write protect done");
  endtask

  // Current-address read returns the byte after the last location a write addressed, protected or not
  task automatic t_read;
    run_cmd(8'hAB, 8'h00, 8'h00, 8'h00, 1);
    check(16'h0000, {15'h0000, nack_err});
    check(16'h00C3, {8'h00, ctl_rd_data});
    $display("test current address read done");
  endtask

  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (20) @(negedge sys_clk);
    t_page;
    t_bad;
    t_protect;
    t_read;
    end_of_test;
  end

  // Watchdog
  initial
  begin
    #900000;
    fail_count++;
    end_of_test;
  end
endmodule
